/* logic/dsidt_pkg.sv */
package dsidt_pkg;

   // ----------------------------------------------------------------
   // Instruction word layout
   // ----------------------------------------------------------------
   localparam int          WORD_W     = 24;
   localparam int          OPC_W      = 8;
   localparam int          OPC_LSB    = 16;
   localparam int          FDST_BIT   = 15;
   localparam int          BYTE_BIT   = 14;
   localparam int          FADR_W     = 13;
   localparam logic [12:0] FADR_MAX   = 13'h1fff;
   localparam int          BPOS_LSB   = 12;
   localparam int          BPOS_W     = 4;
   localparam int          BFADR_W    = 12;
   localparam int          LIT_LSB    = 4;
   localparam int          LIT_W      = 10;
   localparam logic [9:0]  LIT_BYTE_MAX = 10'h0ff;
   localparam int          WN_W       = 4;
   localparam int          LLO_W      = 16;
   localparam int          LHI_W      = 7;
   localparam int          LONG_W     = 23;

   // ----------------------------------------------------------------
   // DSP operand fields
   // ----------------------------------------------------------------
   localparam int          ACC_BIT    = 15;
   localparam int          MUL_LSB    = 12;
   localparam int          AWB_LSB    = 13;
   localparam int          XPF_LSB    = 8;
   localparam int          XD_LSB     = 6;
   localparam int          YPF_LSB    = 2;
   localparam int          YD_LSB     = 0;
   localparam logic [2:0]  MUL_PAIRS  = 3'h6;
   localparam logic [3:0]  PF_HALF    = 4'h7;
   localparam logic [3:0]  PF_W12     = 4'he;
   localparam logic [3:0]  PF_NONE    = 4'hf;
   localparam logic [1:0]  AWB_NONE   = 2'h0;
   localparam logic [1:0]  AWB_REG    = 2'h1;
   localparam logic [1:0]  AWB_IND    = 2'h2;
   localparam logic [3:0]  REG_W0     = 4'h0;
   localparam logic [3:0]  REG_W4     = 4'h4;
   localparam logic [3:0]  REG_W5     = 4'h5;
   localparam logic [3:0]  REG_W6     = 4'h6;
   localparam logic [3:0]  REG_W7     = 4'h7;
   localparam logic [3:0]  REG_W8     = 4'h8;
   localparam logic [3:0]  REG_W9     = 4'h9;
   localparam logic [3:0]  REG_W10    = 4'ha;
   localparam logic [3:0]  REG_W11    = 4'hb;
   localparam logic [3:0]  REG_W12    = 4'hc;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_NOP     = 8'h00;
   localparam logic [7:0] OP_BRA_W   = 8'h01;
   localparam logic [7:0] OP_CALL_W  = 8'h02;
   localparam logic [7:0] OP_GOTO_W  = 8'h03;
   localparam logic [7:0] OP_GOTO    = 8'h04;
   localparam logic [7:0] OP_CALL    = 8'h05;
   localparam logic [7:0] OP_RETURN  = 8'h06;
   localparam logic [7:0] OP_RETINT  = 8'h07;
   localparam logic [7:0] OP_DO      = 8'h08;
   localparam logic [7:0] OP_BRA_C   = 8'h31;
   localparam logic [7:0] OP_BRA     = 8'h37;
   localparam logic [7:0] OP_BIT_W   = 8'ha0;
   localparam logic [7:0] OP_SKIP_W  = 8'ha7;
   localparam logic [7:0] OP_BIT_F   = 8'ha8;
   localparam logic [7:0] OP_SKIP_F  = 8'haf;
   localparam logic [7:0] OP_TEN_BIT_LITERAL   = 8'hb0;
   localparam logic [7:0] OP_FREG    = 8'hb4;
   localparam logic [7:0] OP_TBL     = 8'hba;
   localparam logic [7:0] OP_MOVD    = 8'hbe;
   localparam logic [7:0] OP_DSP     = 8'hc0;
   localparam logic [7:0] OP_DSP_WB  = 8'hc7;
   localparam logic [7:0] OP_CPSKIP  = 8'he6;
   localparam logic [7:0] OP_DSP_SQ  = 8'hf0;

   // ----------------------------------------------------------------
   // Added no-operation cycles
   // ----------------------------------------------------------------
   localparam logic [1:0] EXTRA_JMP  = 2'h1;
   localparam logic [1:0] EXTRA_RET  = 2'h2;
   localparam logic [1:0] EXTRA_MOVD = 2'h1;
   localparam logic [1:0] EXTRA_BRC  = 2'h1;

   typedef enum logic [3:0] {
      CL_NOP, CL_GEN, CL_FREG, CL_LIT, CL_BIT, CL_SKIP, CL_BRC, CL_JMP,
      CL_RET, CL_MOVD, CL_LONG, CL_DSP, CL_SQR, CL_WB
   } dsidt_class_t;

   typedef enum logic [1:0] {
      ST_ISSUE = 2'b00,
      ST_WORD2 = 2'b01,
      ST_STALL = 2'b11
   } dsidt_state_t;

   typedef struct packed {
      logic              en;
      logic [3:0]        base;
      logic signed [3:0] adj;
      logic              w12_off;
   } dsidt_pref_t;

   typedef struct packed {
      logic        acc_b;
      logic [3:0]  mul_a;
      logic [3:0]  mul_b;
      logic        ok;
      dsidt_pref_t xpf;
      dsidt_pref_t ypf;
      logic [3:0]  xd;
      logic [3:0]  yd;
      logic [1:0]  sum_writeback_dest;
   } dsidt_dsp_t;

   typedef struct packed {
      dsidt_class_t cls;
      logic [7:0]   opcode;
      logic         to_file;
      logic         byte_mode;
      logic [12:0]  file_addr;
      logic [3:0]   bit_pos;
      logic [9:0]   ten_bit_literal;
      logic [3:0]   wn;
      logic [22:0]  target;
      dsidt_dsp_t   dsp;
   } dsidt_dec_t;

endpackage

/* logic/dsidt_prefetch_dec.sv */
`timescale 1ns/1ps
module dsidt_prefetch_dec #(
   parameter logic [3:0] BASE_LO = 4'h8,
   parameter logic [3:0] BASE_HI = 4'h9
) (
   input  wire logic [3:0]     code,
   output dsidt_pkg::dsidt_pref_t pref
);

   logic [3:0] idx;

   // Sixteen codes: two bases times seven steps, base plus W12, none
   always_comb begin
      pref         = '0;
      idx          = (code < dsidt_pkg::PF_HALF) ? code : code - dsidt_pkg::PF_HALF;
      pref.en      = (code != dsidt_pkg::PF_NONE);
      pref.w12_off = (code == dsidt_pkg::PF_W12);
      pref.base    = ((code < dsidt_pkg::PF_HALF) && !pref.w12_off) ? BASE_LO : BASE_HI;
      case (idx)
         4'h0:    pref.adj = 4'sh6;
         4'h1:    pref.adj = 4'sh4;
         4'h2:    pref.adj = 4'sh2;
         4'h4:    pref.adj = -4'sh6;
         4'h5:    pref.adj = -4'sh4;
         4'h6:    pref.adj = -4'sh2;
         default: pref.adj = 4'sh0;
      endcase
      if (pref.w12_off || !pref.en) begin
         pref.adj = 4'sh0;
      end
   end

endmodule

/* logic/dsidt_dsp_dec.sv */
`timescale 1ns/1ps
module dsidt_dsp_dec (
   input  wire logic [15:0]        ops,
   input  wire logic               square,
   input  wire logic               wb_form,
   input  dsidt_pkg::dsidt_pref_t  xpf,
   input  dsidt_pkg::dsidt_pref_t  ypf,
   output dsidt_pkg::dsidt_dsp_t   dsp
);

   logic [2:0] mul;
   logic [1:0] sum_writeback_dest;

   // Multiplier pair, prefetch targets and write-back choice
   always_comb begin
      dsp     = '0;
      mul     = ops[dsidt_pkg::MUL_LSB +: 3];
      sum_writeback_dest     = ops[dsidt_pkg::AWB_LSB +: 2];
      dsp.acc_b = ops[dsidt_pkg::ACC_BIT];
      dsp.xpf = xpf;
      dsp.ypf = ypf;
      dsp.xd  = dsidt_pkg::REG_W4 + {2'h0, ops[dsidt_pkg::XD_LSB +: 2]};
      dsp.yd  = dsidt_pkg::REG_W4 + {2'h0, ops[dsidt_pkg::YD_LSB +: 2]};
      dsp.ok  = 1'b1;
      if (wb_form) begin
         dsp.sum_writeback_dest = sum_writeback_dest;
         dsp.ok  = (sum_writeback_dest != 2'h3);
      end else if (square) begin
         dsp.mul_a = dsidt_pkg::REG_W4 + {2'h0, mul[1:0]};
         dsp.mul_b = dsp.mul_a;
      end else begin
         dsp.ok = (mul < dsidt_pkg::MUL_PAIRS);
         case (mul)
            3'h0:    begin dsp.mul_a = dsidt_pkg::REG_W4; dsp.mul_b = dsidt_pkg::REG_W5; end
            3'h1:    begin dsp.mul_a = dsidt_pkg::REG_W4; dsp.mul_b = dsidt_pkg::REG_W6; end
            3'h2:    begin dsp.mul_a = dsidt_pkg::REG_W4; dsp.mul_b = dsidt_pkg::REG_W7; end
            3'h3:    begin dsp.mul_a = dsidt_pkg::REG_W5; dsp.mul_b = dsidt_pkg::REG_W6; end
            3'h4:    begin dsp.mul_a = dsidt_pkg::REG_W5; dsp.mul_b = dsidt_pkg::REG_W7; end
            3'h5:    begin dsp.mul_a = dsidt_pkg::REG_W6; dsp.mul_b = dsidt_pkg::REG_W7; end
            default: begin dsp.mul_a = dsidt_pkg::REG_W4; dsp.mul_b = dsidt_pkg::REG_W5; end
         endcase
      end
   end

endmodule

/* logic/dsidt_decoder.sv */
`timescale 1ns/1ps
module dsidt_decoder (
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire logic [23:0]        instr_word,
   input  wire logic               instr_valid,
   input  wire logic               cond_true,
   output logic                    fetch_ready,
   output logic                    pc_reload,
   output logic                    exec_write_en,
   output logic                    illegal_op,
   output dsidt_pkg::dsidt_dec_t   decoded
);

   // ----------------------------------------------------------------
   // Field decode of the word at the fetch port
   // ----------------------------------------------------------------
   dsidt_pkg::dsidt_class_t cls_now;
   dsidt_pkg::dsidt_dec_t   dec_now;
   dsidt_pkg::dsidt_pref_t  xpf_now;
   dsidt_pkg::dsidt_pref_t  ypf_now;
   dsidt_pkg::dsidt_dsp_t   dsp_now;
   logic [7:0]              opc;
   logic [15:0]             ops;
   logic                    bad_now;

   assign opc = instr_word[dsidt_pkg::OPC_LSB +: dsidt_pkg::OPC_W];
   assign ops = instr_word[dsidt_pkg::LLO_W-1:0];

   dsidt_prefetch_dec #(
      .BASE_LO (dsidt_pkg::REG_W8),
      .BASE_HI (dsidt_pkg::REG_W9)
   ) u_xpf (
      .code (ops[dsidt_pkg::XPF_LSB +: 4]),
      .pref (xpf_now)
   );

   dsidt_prefetch_dec #(
      .BASE_LO (dsidt_pkg::REG_W10),
      .BASE_HI (dsidt_pkg::REG_W11)
   ) u_ypf (
      .code (ops[dsidt_pkg::YPF_LSB +: 4]),
      .pref (ypf_now)
   );

   dsidt_dsp_dec u_dsp (
      .ops     (ops),
      .square  (cls_now == dsidt_pkg::CL_SQR),
      .wb_form (cls_now == dsidt_pkg::CL_WB),
      .xpf     (xpf_now),
      .ypf     (ypf_now),
      .dsp     (dsp_now)
   );

   always_comb begin
      case (opc)
         dsidt_pkg::OP_NOP:    cls_now = dsidt_pkg::CL_NOP;
         dsidt_pkg::OP_BRA_W,
         dsidt_pkg::OP_CALL_W,
         dsidt_pkg::OP_GOTO_W,
         dsidt_pkg::OP_BRA,
         dsidt_pkg::OP_TBL:    cls_now = dsidt_pkg::CL_JMP;
         dsidt_pkg::OP_RETURN,
         dsidt_pkg::OP_RETINT: cls_now = dsidt_pkg::CL_RET;
         dsidt_pkg::OP_GOTO,
         dsidt_pkg::OP_CALL,
         dsidt_pkg::OP_DO:     cls_now = dsidt_pkg::CL_LONG;
         dsidt_pkg::OP_BRA_C:  cls_now = dsidt_pkg::CL_BRC;
         dsidt_pkg::OP_SKIP_W,
         dsidt_pkg::OP_SKIP_F,
         dsidt_pkg::OP_CPSKIP: cls_now = dsidt_pkg::CL_SKIP;
         dsidt_pkg::OP_BIT_W,
         dsidt_pkg::OP_BIT_F:  cls_now = dsidt_pkg::CL_BIT;
         dsidt_pkg::OP_TEN_BIT_LITERAL:  cls_now = dsidt_pkg::CL_LIT;
         dsidt_pkg::OP_FREG:   cls_now = dsidt_pkg::CL_FREG;
         dsidt_pkg::OP_MOVD:   cls_now = dsidt_pkg::CL_MOVD;
         dsidt_pkg::OP_DSP:    cls_now = dsidt_pkg::CL_DSP;
         dsidt_pkg::OP_DSP_SQ: cls_now = dsidt_pkg::CL_SQR;
         dsidt_pkg::OP_DSP_WB: cls_now = dsidt_pkg::CL_WB;
         default:              cls_now = dsidt_pkg::CL_GEN;
      endcase
   end

   // Operand fields and their legal ranges
   always_comb begin
      dec_now        = '0;
      dec_now.cls    = cls_now;
      dec_now.opcode = opc;
      dec_now.wn     = ops[dsidt_pkg::WN_W-1:0];
      dec_now.dsp    = dsp_now;
      bad_now        = 1'b0;
      case (cls_now)
         // Result to f or to the default work register
         dsidt_pkg::CL_FREG: begin
            dec_now.to_file   = ops[dsidt_pkg::FDST_BIT];
            dec_now.byte_mode = ops[dsidt_pkg::BYTE_BIT];
            dec_now.file_addr = ops[dsidt_pkg::FADR_W-1:0] & dsidt_pkg::FADR_MAX;
            if (!dec_now.to_file) begin
               dec_now.wn = dsidt_pkg::REG_W0;
            end
         end
         dsidt_pkg::CL_BIT,
         dsidt_pkg::CL_SKIP: begin
            dec_now.bit_pos   = ops[dsidt_pkg::BPOS_LSB +: dsidt_pkg::BPOS_W];
            dec_now.to_file   = (opc == dsidt_pkg::OP_BIT_F) || (opc == dsidt_pkg::OP_SKIP_F);
            dec_now.file_addr = {ops[dsidt_pkg::BFADR_W-1:0], 1'b0};
         end
         dsidt_pkg::CL_LIT: begin
            dec_now.byte_mode = ops[dsidt_pkg::BYTE_BIT];
            dec_now.ten_bit_literal     = ops[dsidt_pkg::LIT_LSB +: dsidt_pkg::LIT_W];
            bad_now           = dec_now.byte_mode && (dec_now.ten_bit_literal > dsidt_pkg::LIT_BYTE_MAX);
         end
         // Accumulator choice rides in every DSP form
         dsidt_pkg::CL_DSP,
         dsidt_pkg::CL_SQR,
         dsidt_pkg::CL_WB:  bad_now = !dsp_now.ok;
         default:           bad_now = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Issue sequencer
   // ----------------------------------------------------------------
   dsidt_pkg::dsidt_state_t state_reg, state_next;
   dsidt_pkg::dsidt_dec_t   dec_reg, dec_next;
   logic [1:0]              cnt_reg, cnt_next;
   logic                    skip_reg, skip_next;
   logic                    skip2_reg, skip2_next;
   logic [15:0]             first_reg, first_next;
   logic                    wr_reg, wr_next;
   logic                    reload_reg, reload_next;
   logic                    bad_reg, bad_next;

   // Sequencing, added cycles and write suppression
   always_comb begin
      state_next  = state_reg;
      dec_next    = dec_reg;
      cnt_next    = cnt_reg;
      skip_next   = skip_reg;
      skip2_next  = skip2_reg;
      first_next  = first_reg;
      wr_next     = 1'b0;
      reload_next = 1'b0;
      bad_next    = 1'b0;
      case (state_reg)
         dsidt_pkg::ST_ISSUE: begin
            if (instr_valid && skip_reg) begin
               // Skipped word runs as a no-op
               skip_next    = 1'b0;
               dec_next     = '0;
               if (cls_now == dsidt_pkg::CL_LONG) begin
                  state_next = dsidt_pkg::ST_WORD2;
                  skip2_next = 1'b1;
               end
            end else if (instr_valid) begin
               dec_next = dec_now;
               bad_next = bad_now;
               // Zero top byte alone does nothing
               wr_next  = (cls_now != dsidt_pkg::CL_NOP);
               case (cls_now)
                  dsidt_pkg::CL_LONG: begin
                     // First word held until its partner
                     wr_next    = 1'b0;
                     first_next = ops;
                     state_next = dsidt_pkg::ST_WORD2;
                  end
                  // Jump and table forms take two cycles
                  dsidt_pkg::CL_JMP: begin
                     reload_next = (opc != dsidt_pkg::OP_TBL);
                     cnt_next    = dsidt_pkg::EXTRA_JMP;
                     state_next  = dsidt_pkg::ST_STALL;
                  end
                  dsidt_pkg::CL_RET: begin
                     reload_next = 1'b1;
                     cnt_next    = dsidt_pkg::EXTRA_RET;
                     state_next  = dsidt_pkg::ST_STALL;
                  end
                  dsidt_pkg::CL_MOVD: begin
                     cnt_next   = dsidt_pkg::EXTRA_MOVD;
                     state_next = dsidt_pkg::ST_STALL;
                  end
                  dsidt_pkg::CL_BRC: begin
                     if (cond_true) begin
                        reload_next = 1'b1;
                        cnt_next    = dsidt_pkg::EXTRA_BRC;
                        state_next  = dsidt_pkg::ST_STALL;
                     end
                  end
                  dsidt_pkg::CL_SKIP: skip_next = cond_true;
                  default:            skip_next = 1'b0;
               endcase
            end
         end
         dsidt_pkg::ST_WORD2: begin
            if (instr_valid) begin
               state_next = dsidt_pkg::ST_ISSUE;
               skip2_next = 1'b0;
               if (!skip2_reg) begin
                  wr_next     = 1'b1;
                  reload_next = (dec_reg.opcode != dsidt_pkg::OP_DO);
                  dec_next.target = {instr_word[dsidt_pkg::LHI_W-1:0],
                                     first_reg[dsidt_pkg::LLO_W-1:1], 1'b0};
                  // Second word must have a zero top byte
                  bad_next = (opc != dsidt_pkg::OP_NOP) || first_reg[0];
               end
            end
         end
         dsidt_pkg::ST_STALL: begin
            cnt_next = cnt_reg - 2'h1;
            if (cnt_reg == 2'h1) begin
               state_next = dsidt_pkg::ST_ISSUE;
            end
         end
         default: state_next = dsidt_pkg::ST_ISSUE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= dsidt_pkg::ST_ISSUE;
         dec_reg    <= '0;
         cnt_reg    <= 2'h0;
         skip_reg   <= 1'b0;
         skip2_reg  <= 1'b0;
         first_reg  <= 16'h0000;
         wr_reg     <= 1'b0;
         reload_reg <= 1'b0;
         bad_reg    <= 1'b0;
      end else begin
         state_reg  <= state_next;
         dec_reg    <= dec_next;
         cnt_reg    <= cnt_next;
         skip_reg   <= skip_next;
         skip2_reg  <= skip2_next;
         first_reg  <= first_next;
         wr_reg     <= wr_next;
         reload_reg <= reload_next;
         bad_reg    <= bad_next;
      end
   end

   assign fetch_ready   = (state_reg != dsidt_pkg::ST_STALL);
   assign pc_reload     = reload_reg;
   assign exec_write_en = wr_reg;
   assign illegal_op    = bad_reg;
   assign decoded       = dec_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic issue;
   assign issue = (state_reg == dsidt_pkg::ST_ISSUE) && instr_valid && !skip_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_ret_three_cycles: assert property (
      issue && cls_now == dsidt_pkg::CL_RET
      |=> (pc_reload && !fetch_ready) ##1 !fetch_ready ##1 fetch_ready)
      else $error("return did not take three cycles");
   a_jump_two_cycles: assert property (
      issue && cls_now == dsidt_pkg::CL_JMP |=> !fetch_ready ##1 fetch_ready)
      else $error("jump did not take two cycles");
   a_branch_taken: assert property (
      issue && cls_now == dsidt_pkg::CL_BRC && cond_true |=> pc_reload && !fetch_ready)
      else $error("taken branch did not add a cycle");
   a_branch_fall: assert property (
      issue && cls_now == dsidt_pkg::CL_BRC && !cond_true |=> fetch_ready && !pc_reload)
      else $error("untaken branch stalled");
   a_stall_no_write: assert property (
      state_reg == dsidt_pkg::ST_STALL |=> !exec_write_en)
      else $error("write during added cycle");
   a_long_second: assert property (
      issue && cls_now == dsidt_pkg::CL_LONG
      |=> !exec_write_en && state_reg == dsidt_pkg::ST_WORD2)
      else $error("two-word form wrote on its first word");
   a_word2_done: assert property (
      state_reg == dsidt_pkg::ST_WORD2 && instr_valid && !skip2_reg |=> exec_write_en)
      else $error("two-word form did not complete on second word");
   a_word2_top: assert property (
      state_reg == dsidt_pkg::ST_WORD2 && instr_valid && !skip2_reg && opc != 8'h00
      |=> illegal_op)
      else $error("nonzero top byte of second word not flagged");
   a_orphan_nop: assert property (
      issue && opc == dsidt_pkg::OP_NOP |=> !exec_write_en && !pc_reload)
      else $error("lone second word had an effect");
   a_skip_squash: assert property (
      issue && cls_now == dsidt_pkg::CL_SKIP && cond_true ##1 instr_valid
      |=> !exec_write_en)
      else $error("skipped word was not squashed");
   a_target_even: assert property (
      $rose(pc_reload) && decoded.cls == dsidt_pkg::CL_LONG |-> decoded.target[0] == 1'b0)
      else $error("long target odd");
   a_file_dest: assert property (
      issue && cls_now == dsidt_pkg::CL_FREG && !ops[15] |=> decoded.wn == 4'h0)
      else $error("file op result not sent to W0");

   c_taken_branch: cover property (issue && cls_now == dsidt_pkg::CL_BRC && cond_true);
   c_skip_long: cover property (skip_reg && instr_valid && cls_now == dsidt_pkg::CL_LONG);
   c_return: cover property (issue && cls_now == dsidt_pkg::CL_RET);
   c_long_call: cover property (state_reg == dsidt_pkg::ST_WORD2 && instr_valid && !skip2_reg);

endmodule

/* test/dsidt_prog_mem.sv */
`timescale 1ns/1ps
module dsidt_prog_mem (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        restart,
   input  wire logic        fetch_ready,
   output logic [23:0]      instr_word,
   output logic             instr_valid
);
   logic [23:0] mem [0:2] = '{24'h0, 24'h0, 24'h0};
   logic [1:0]  pc_reg;
   // Word pointer, held while the decoder stalls; 3 means nothing left
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) pc_reg <= 2'h3;
      else if (restart) pc_reg <= 2'h0;
      else if (instr_valid && fetch_ready) pc_reg <= pc_reg + 2'h1;
   end
   // Idle bus shows the inverse of the last word, not a stale copy
   assign #1 instr_valid = !restart && pc_reg != 2'h3;
   assign #1 instr_word  = instr_valid ? mem[pc_reg] : ~mem[2];
endmodule

/* test/test_dsidt_decoder.sv */
`timescale 1ns/1ps
module test_dsidt_decoder;
   typedef struct {
      logic [23:0] a, b, c;
      logic cnd;
      int cyc, rel, ill;
      dsidt_pkg::dsidt_class_t cls;
   } dsidt_row_t;
   localparam logic [23:0]             fw = 24'hb49fff; // File op to f, top address
   localparam dsidt_pkg::dsidt_class_t fr = dsidt_pkg::CL_FREG;
   localparam dsidt_pkg::dsidt_class_t np = dsidt_pkg::CL_NOP;
   logic                  ref_clk, rst_n, restart, cond_true, instr_valid, fetch_ready;
   logic                  pc_reload, illegal_op, exec_write_en;
   logic [23:0]           instr_word;
   dsidt_pkg::dsidt_dec_t d;
   int                    mismatches = 0, compares = 0, cycles = 0, cyc, rel, ill, wr;
   // Words, condition, cycles, reloads, illegal pulses, final class
   dsidt_row_t rows [24] = '{
      '{fw, fw, fw, 0, 3, 0, 0, fr},
      '{24'h370000, fw, fw, 0, 4, 1, 0, fr},
      '{24'h010003, fw, fw, 0, 4, 1, 0, fr},
      '{24'h020003, fw, fw, 0, 4, 1, 0, fr},
      '{24'h030003, fw, fw, 0, 4, 1, 0, fr},
      '{24'hba0000, fw, fw, 0, 4, 0, 0, fr},
      '{24'h060000, fw, fw, 0, 5, 1, 0, fr},
      '{24'h070000, fw, fw, 0, 5, 1, 0, fr},
      '{24'h310010, fw, fw, 1, 4, 1, 0, fr},
      '{24'h310010, fw, fw, 0, 3, 0, 0, fr},
      '{24'hbe0000, fw, fw, 0, 4, 0, 0, fr},
      '{24'h041234, 24'h000001, fw, 0, 3, 1, 0, fr},
      '{24'h051234, 24'h000001, fw, 0, 3, 1, 0, fr},
      '{24'h081234, 24'h000001, fw, 0, 3, 0, 0, fr},
      '{24'ha70000, 24'h041234, 24'h000001, 1, 3, 0, 0, np},
      '{24'haf0000, 24'h041234, 24'h000001, 1, 3, 0, 0, np},
      '{24'he60000, 24'h041234, 24'h000001, 1, 3, 0, 0, np},
      '{24'ha70000, fw, fw, 0, 3, 0, 0, fr},
      '{fw, fw, 24'h000005, 0, 3, 0, 0, np},
      '{24'hc06000, fw, fw, 0, 3, 0, 1, fr},
      '{24'hc76000, fw, fw, 0, 3, 0, 1, fr},
      '{24'hb05000, fw, fw, 0, 3, 0, 1, fr},
      '{24'h040001, 24'h000000, fw, 0, 3, 1, 1, fr},
      '{24'hb03ff0, fw, fw, 0, 3, 0, 0, fr}};
   // Expected write pulses per row: squashed and lone second words write nothing
   int wrs [24] = '{3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 2, 2, 2, 1, 1, 1, 3, 2, 3, 3, 3, 2, 3};
   dsidt_decoder u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr_word(instr_word),
      .instr_valid(instr_valid), .cond_true(cond_true), .fetch_ready(fetch_ready),
      .pc_reload(pc_reload), .exec_write_en(exec_write_en), .illegal_op(illegal_op),
      .decoded(d));
   dsidt_prog_mem u_mem (.ref_clk(ref_clk), .rst_n(rst_n), .restart(restart),
      .fetch_ready(fetch_ready), .instr_word(instr_word), .instr_valid(instr_valid));
   // Clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 1000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   // Load three words, then count cycles until all are taken, plus pulses
   task automatic run(input logic [23:0] a, b, c, input logic cnd);
      logic [1:0] p;
      u_mem.mem[0] = a;
      u_mem.mem[1] = b;
      u_mem.mem[2] = c;
      cond_true = cnd;
      restart = 1'b1;
      @(posedge ref_clk);
      #1 restart = 1'b0;
      {cyc, rel, ill, wr} = '0;
      repeat (8) begin
         p = u_mem.pc_reg;
         @(posedge ref_clk);
         #1;
         cyc += int'(p != 2'h3);
         rel += int'(pc_reload === 1'b1);
         ill += int'(illegal_op === 1'b1);
         wr += int'(exec_write_en === 1'b1);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Main sequence: table first, then field layouts and reset
   initial begin
      {rst_n, restart, cond_true} = '0;
      repeat (10) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      foreach (rows[i]) begin
         run(rows[i].a, rows[i].b, rows[i].c, rows[i].cnd);
         chk(cyc == rows[i].cyc && rel == rows[i].rel && ill == rows[i].ill && wr == wrs[i]
             && d.cls === rows[i].cls, $sformatf("row %0d", i));
      end
      chk(d.to_file === 1'b1 && d.file_addr === 13'h1fff, "file fields");
      run(fw, fw, 24'hb41234, 0);
      chk(d.to_file === 1'b0 && d.wn === dsidt_pkg::REG_W0 && d.file_addr === 13'h1234,
          "file to default work register");
      run(fw, fw, 24'ha8f123, 0);
      chk(d.bit_pos === 4'hf && d.file_addr === 13'h0246, "bit fields");
      run(fw, 24'h05abce, 24'h00007f, 0);
      chk(d.target === 23'h7fabce, "long target");
      run(fw, fw, 24'hc7cefc, 0);
      chk(d.dsp.acc_b === 1'b1 && d.dsp.sum_writeback_dest === dsidt_pkg::AWB_IND && d.dsp.xpf.w12_off === 1'b1
          && d.dsp.xpf.base === dsidt_pkg::REG_W9 && d.dsp.xd === dsidt_pkg::REG_W7
          && d.dsp.ypf.en === 1'b0 && d.dsp.yd === dsidt_pkg::REG_W4, "dsp form");
      run(fw, fw, 24'hf02000, 0);
      chk(d.dsp.mul_a === dsidt_pkg::REG_W6 && d.dsp.mul_b === dsidt_pkg::REG_W6, "square");
      run(fw, fw, 24'hc05000, 0);
      chk(d.dsp.mul_a === dsidt_pkg::REG_W6 && d.dsp.mul_b === dsidt_pkg::REG_W7
          && d.dsp.ypf.base === dsidt_pkg::REG_W10 && d.dsp.ypf.adj === 4'sh6, "pair");
      // Reset in the middle of a return stall
      u_mem.mem[0] = 24'h060000;
      restart = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 restart = 1'b0;
      @(posedge ref_clk);
      #1 rst_n = 1'b0;
      #1 chk(fetch_ready === 1'b1 && pc_reload === 1'b0 && illegal_op === 1'b0
             && exec_write_en === 1'b0, "reset");
      @(posedge ref_clk);
      #1 rst_n = 1'b1;
      run(fw, fw, fw, 0);
      chk(cyc == 3 && rel == 0 && wr == 3 && d.cls === fr, "after reset");
      tally_and_finish();
   end
endmodule
